// File: inc/atb_map.vh
// Purpose: Register map, field layout and mode codes for the timer time base
// Assumes: 32-bit register port, word addresses as byte offsets
// Notes:   Included by logic/atb_top.v, the port checker and the bench
`ifndef ATB_MAP_VH
`define ATB_MAP_VH

// Register offsets
`define ATB_CTL0_ADDR    8'h00
`define ATB_SLAVE_ADDR   8'h04
`define ATB_SWEV_ADDR    8'h08
`define ATB_FLAG_ADDR    8'h0C
`define ATB_CNT_ADDR     8'h10
`define ATB_PSC_ADDR     8'h14
`define ATB_CAR_ADDR     8'h18
`define ATB_REP_ADDR     8'h1C

// Control register 0 fields
`define ATB_CTL_EN_BIT   0
`define ATB_CTL_UPD_BIT  1
`define ATB_CTL_DIR_BIT  4
`define ATB_CTL_CAM_LO   5
`define ATB_CTL_CAM_HI   6

// Slave configuration fields
`define ATB_SMC_LO       0
`define ATB_SMC_HI       2
`define ATB_TRG_LO       4
`define ATB_TRG_HI       6
`define ATB_ECM1_BIT     14

// Other bits
`define ATB_UPG_BIT      0
`define ATB_UPF_BIT      0

// Mode codes
`define ATB_SMC_INT      3'h0
`define ATB_SMC_EXT0     3'h7
`define ATB_TRG_ITI_MAX  3'h3
`define ATB_TRG_ETI      3'h7
`define ATB_TRG_PIN1     3'h6
`define ATB_SMC_TRG1     3'h1
`define ATB_SMC_TRG2     3'h2
`define ATB_SMC_TRG3     3'h3
`define ATB_CAM_EDGE     2'h0

// Reset values and count step
`define ATB_ZERO16       16'h0000
`define ATB_ZERO8        8'h00
`define ATB_ONE16        16'h0001

`endif

// File: logic/atb_top.v
// Purpose: Time base of a four-channel advanced timer: clock source, prescaler,
//          up/down/center counter, repetition and update event generation
// Assumes: All inputs synchronous to SYS_CLK; EXT_TRIGGER_IN already digitally filtered
// Notes:   Count clock is a one-cycle enable pulse inside SYS_CLK domain
//
// Summary of operation
// - Slave mode zero: kernel clock feeds prescaler
// - Modes 1,2,3,7: trigger select picks clock
// - Modes 4,5,6: kernel clock still drives prescaler
// - Mode 7, select 4-6: channel pin edges clock
// - Mode 7, select 0-3: internal trigger rising edges
// - Filtered trigger clocks if mode1 bit or 7/7
// - One prescaler pulse per filtered trigger rise
// - Prescaler divides by value plus one
// - New prescale value applied at update only
// - Up count to reload, wrap, overflow
// - Update after repeat value plus one events
// - Up mode software update clears counter
// - Down count to zero, reload, underflow
// - Down mode software update loads reload
// - Update disable blocks all update events
// - Update loads repeat, reload, prescale shadows
// - Center mode counts up then down
// - Center overflow at reload-1, underflow at 1
// - Center mode direction bit is read-only status
// - Center mode software update clears counter
// - Center mode flag set on either event
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "atb_map.vh"

module atb_top (
    // Clock and reset
    input  wire        SYS_CLK,
    input  wire        RESETN,
    // Register port
    input  wire [7:0]  REG_ADDR,
    input  wire [31:0] REG_WDATA,
    input  wire        REG_WR,
    input  wire        REG_RD,
    output reg  [31:0] REG_RDATA,
    // Clock and trigger sources
    input  wire [3:0]  INTERNAL_TRIG_IN,
    input  wire        CHAN0_PIN,
    input  wire        CHAN1_PIN,
    input  wire        EXT_TRIGGER_IN,
    // Time base status
    output reg  [15:0] COUNT_VALUE,
    output reg         UPDATE_EVENT,
    output reg         UPDATE_FLAG
);

    // Software visible registers
    reg         counter_enable_q;
    reg         update_disable_q;
    reg         dir_q;
    reg  [1:0]  align_mode_sel_q;
    reg  [2:0]  slave_mode_sel_q;
    reg  [2:0]  trigger_source_sel_q;
    reg         ext_clk_mode1_en_q;
    reg  [15:0] prescale_value_q;
    reg  [15:0] reload_value_q;
    reg  [7:0]  repeat_value_q;
    // Shadows and working state
    reg  [15:0] psc_shadow_q;
    reg  [15:0] car_shadow_q;
    reg  [7:0]  rep_shadow_q;
    reg  [15:0] psc_cnt_q;
    reg  [7:0]  rep_cnt_q;
    reg  [15:0] cnt_q;
    reg  [3:0]  iti_prev_q;
    reg         ch0_prev_q;
    reg         ch1_prev_q;
    reg         eti_prev_q;

    wire wr_ctl   = REG_WR && (REG_ADDR == `ATB_CTL0_ADDR);
    wire wr_slave = REG_WR && (REG_ADDR == `ATB_SLAVE_ADDR);
    wire wr_swev  = REG_WR && (REG_ADDR == `ATB_SWEV_ADDR);
    wire wr_flag  = REG_WR && (REG_ADDR == `ATB_FLAG_ADDR);
    wire wr_cnt   = REG_WR && (REG_ADDR == `ATB_CNT_ADDR);
    wire wr_psc   = REG_WR && (REG_ADDR == `ATB_PSC_ADDR);
    wire wr_car   = REG_WR && (REG_ADDR == `ATB_CAR_ADDR);
    wire wr_rep   = REG_WR && (REG_ADDR == `ATB_REP_ADDR);
    wire sw_update_gen = wr_swev && REG_WDATA[`ATB_UPG_BIT];

    wire center = (align_mode_sel_q != `ATB_CAM_EDGE);

    // Edge detection of the external sources
    wire [3:0] iti_rise = INTERNAL_TRIG_IN & ~iti_prev_q;
    wire       ch0_edge = CHAN0_PIN ^ ch0_prev_q;
    wire       ch1_edge = CHAN1_PIN ^ ch1_prev_q;
    wire       eti_rise = EXT_TRIGGER_IN & ~eti_prev_q;

    // Trigger selected pulse; channel selects take both edges as a simplification
    function trig_pulse;
        input [2:0] sel;
        input [3:0] iti;
        input       c0;
        input       c1;
        input       et;
        begin
            if (sel <= `ATB_TRG_ITI_MAX)
                trig_pulse = iti[sel[1:0]];
            else if (sel == `ATB_TRG_ETI)
                trig_pulse = et;
            else if (sel == `ATB_TRG_PIN1)
                trig_pulse = c1;
            else
                trig_pulse = c0;
        end
    endfunction

    // Prescaler input clock select, as enable pulse
    reg prescaler_input_clk;
    always @* begin
        if (ext_clk_mode1_en_q)
            prescaler_input_clk = eti_rise;
        else begin
            case (slave_mode_sel_q)
                `ATB_SMC_INT: prescaler_input_clk = 1'b1;
                `ATB_SMC_TRG1, `ATB_SMC_TRG2, `ATB_SMC_TRG3, `ATB_SMC_EXT0:
                    prescaler_input_clk = trig_pulse(trigger_source_sel_q, iti_rise,
                                                     ch0_edge, ch1_edge, eti_rise);
                default: prescaler_input_clk = 1'b1;
            endcase
        end
    end

    // Divider by shadow value plus one
    wire tick      = counter_enable_q && prescaler_input_clk;
    wire count_clk = tick && (psc_cnt_q == psc_shadow_q);

    // Counter events
    wire overflow = count_clk && (center ?
                    (~dir_q && cnt_q == car_shadow_q - `ATB_ONE16) :
                    (~dir_q && cnt_q >= car_shadow_q));
    wire underflow = count_clk && (center ?
                    (dir_q && cnt_q == `ATB_ONE16) :
                    (dir_q && cnt_q == `ATB_ZERO16));
    wire flow      = overflow || underflow;
    wire rep_done  = (rep_cnt_q == `ATB_ZERO8);
    wire hw_update = flow && rep_done;
    wire update    = (hw_update || sw_update_gen) && !update_disable_q;

    // Edge history of the internal trigger lines, one flop per line
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_iti_hist
            always @(posedge SYS_CLK or negedge RESETN) begin
                if (!RESETN)
                    iti_prev_q[gi] <= 1'b0;
                else
                    iti_prev_q[gi] <= INTERNAL_TRIG_IN[gi];
            end
        end
    endgenerate

    // Edge history of the pins; reset level matches the idle low of the lines,
    // so no false edge follows reset
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ch0_prev_q <= 1'b0;
            ch1_prev_q <= 1'b0;
            eti_prev_q <= 1'b0;
        end else begin
            ch0_prev_q <= CHAN0_PIN;
            ch1_prev_q <= CHAN1_PIN;
            eti_prev_q <= EXT_TRIGGER_IN;
        end
    end

    // Control and preload registers written from the register port
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            counter_enable_q     <= 1'b0;
            update_disable_q     <= 1'b0;
            align_mode_sel_q     <= `ATB_CAM_EDGE;
            slave_mode_sel_q     <= `ATB_SMC_INT;
            trigger_source_sel_q <= 3'h0;
            ext_clk_mode1_en_q   <= 1'b0;
            prescale_value_q     <= `ATB_ZERO16;
            reload_value_q       <= `ATB_ZERO16;
            repeat_value_q       <= `ATB_ZERO8;
        end else begin
            if (wr_ctl) begin
                counter_enable_q <= REG_WDATA[`ATB_CTL_EN_BIT];
                update_disable_q <= REG_WDATA[`ATB_CTL_UPD_BIT];
                align_mode_sel_q <= REG_WDATA[`ATB_CTL_CAM_HI:`ATB_CTL_CAM_LO];
            end
            if (wr_slave) begin
                slave_mode_sel_q     <= REG_WDATA[`ATB_SMC_HI:`ATB_SMC_LO];
                trigger_source_sel_q <= REG_WDATA[`ATB_TRG_HI:`ATB_TRG_LO];
                ext_clk_mode1_en_q   <= REG_WDATA[`ATB_ECM1_BIT];
            end
            // Preloads only; divider and counter see them at the next update
            if (wr_psc)
                prescale_value_q <= REG_WDATA[15:0];
            if (wr_car)
                reload_value_q <= REG_WDATA[15:0];
            if (wr_rep)
                repeat_value_q <= REG_WDATA[7:0];
        end
    end

    // Prescaler divider; an update restarts it so a new ratio starts clean
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN)
            psc_cnt_q <= `ATB_ZERO16;
        else if (update)
            psc_cnt_q <= `ATB_ZERO16;
        else if (tick)
            psc_cnt_q <= count_clk ? `ATB_ZERO16 : psc_cnt_q + `ATB_ONE16;
    end

    // Next counter value and direction
    reg  [15:0] cnt_d;
    reg         dir_d;
    always @* begin
        cnt_d = cnt_q;
        dir_d = dir_q;
        // Direction is software owned only in edge mode
        if (wr_ctl && !center)
            dir_d = REG_WDATA[`ATB_CTL_DIR_BIT];
        if (update && sw_update_gen) begin
            if (!center && dir_q)
                cnt_d = reload_value_q;
            else
                cnt_d = `ATB_ZERO16;
            if (center)
                dir_d = 1'b0;
        end else if (wr_cnt) begin
            cnt_d = REG_WDATA[15:0];
        end else if (count_clk) begin
            if (center) begin
                // Direction turns at the ends, shown read-only
                if (!dir_q) begin
                    if (cnt_q >= car_shadow_q) begin
                        dir_d = 1'b1;
                        cnt_d = car_shadow_q - `ATB_ONE16;
                    end else begin
                        cnt_d = cnt_q + `ATB_ONE16;
                    end
                end else begin
                    if (cnt_q == `ATB_ZERO16) begin
                        dir_d = 1'b0;
                        cnt_d = `ATB_ONE16;
                    end else begin
                        cnt_d = cnt_q - `ATB_ONE16;
                    end
                end
            end else if (!dir_q) begin
                cnt_d = overflow ? `ATB_ZERO16 : cnt_q + `ATB_ONE16;
            end else begin
                cnt_d = underflow ? car_shadow_q : cnt_q - `ATB_ONE16;
            end
        end
    end

    // Counter and direction flops
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            cnt_q <= `ATB_ZERO16;
            dir_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
        end
    end

    // Repetition counter; with updates disabled it still wraps on its shadow
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN)
            rep_cnt_q <= `ATB_ZERO8;
        else if (update)
            rep_cnt_q <= repeat_value_q;
        else if (flow)
            rep_cnt_q <= rep_done ? rep_shadow_q : rep_cnt_q - 8'h01;
    end

    // Shadow loads, all three on the same update
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            psc_shadow_q <= `ATB_ZERO16;
            car_shadow_q <= `ATB_ZERO16;
            rep_shadow_q <= `ATB_ZERO8;
        end else if (update) begin
            psc_shadow_q <= prescale_value_q;
            car_shadow_q <= reload_value_q;
            rep_shadow_q <= repeat_value_q;
        end
    end

    // Sticky flag, set wins over a clear in the same cycle
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN)
            UPDATE_FLAG <= 1'b0;
        else if (update)
            UPDATE_FLAG <= 1'b1;
        else if (wr_flag && !REG_WDATA[`ATB_UPF_BIT])
            UPDATE_FLAG <= 1'b0;
    end

    // Status outputs, one cycle behind the internal state
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            UPDATE_EVENT <= 1'b0;
            COUNT_VALUE  <= `ATB_ZERO16;
        end else begin
            UPDATE_EVENT <= update;
            COUNT_VALUE  <= cnt_q;
        end
    end

    // Read mux; unmapped offsets read as zero
    function [31:0] rd_mux;
        input [7:0] a;
        begin
            case (a)
                `ATB_CTL0_ADDR:  rd_mux = {25'h0, align_mode_sel_q, dir_q, 2'h0,
                                           update_disable_q, counter_enable_q};
                `ATB_SLAVE_ADDR: rd_mux = {17'h0, ext_clk_mode1_en_q, 7'h0,
                                           trigger_source_sel_q, 1'b0,
                                           slave_mode_sel_q};
                `ATB_FLAG_ADDR:  rd_mux = {31'h0, UPDATE_FLAG};
                `ATB_CNT_ADDR:   rd_mux = {16'h0, cnt_q};
                `ATB_PSC_ADDR:   rd_mux = {16'h0, prescale_value_q};
                `ATB_CAR_ADDR:   rd_mux = {16'h0, reload_value_q};
                `ATB_REP_ADDR:   rd_mux = {24'h0, repeat_value_q};
                default:         rd_mux = 32'h00000000;
            endcase
        end
    endfunction

    // Read data stand only in the cycle after the strobe, zero otherwise,
    // so a bus that ORs several slaves needs no extra gating
    always @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN)
            REG_RDATA <= 32'h00000000;
        else if (REG_RD)
            REG_RDATA <= rd_mux(REG_ADDR);
        else
            REG_RDATA <= 32'h00000000;
    end

endmodule // atb_top

// File: tb/atb_chk.sv
// Purpose: Port checker for the time base
// Assumes: Offsets of atb_map.vh
// Notes:   Enable and disable bits are tracked from bus writes
`timescale 1ns/1ps
`include "atb_map.vh"
module atb_chk (
    // Clock and reset
    input wire        SYS_CLK,
    input wire        RESETN,
    // Register port
    input wire [7:0]  REG_ADDR,
    input wire [31:0] REG_WDATA,
    input wire        REG_WR,
    input wire        REG_RD,
    input wire [31:0] REG_RDATA,
    // Status
    input wire [15:0] COUNT_VALUE,
    input wire        UPDATE_EVENT,
    input wire        UPDATE_FLAG
);
    logic [1:0] ctl_q;
    wire        swu = REG_WR && REG_ADDR == `ATB_SWEV_ADDR && REG_WDATA[0] && !ctl_q[1];
    wire        clr = REG_WR && REG_ADDR == `ATB_FLAG_ADDR && !REG_WDATA[0];
    always_ff @(posedge SYS_CLK or negedge RESETN)
        if (!RESETN) ctl_q <= 2'h0;
        else if (REG_WR && REG_ADDR == `ATB_CTL0_ADDR) ctl_q <= REG_WDATA[1:0];
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    sequence s_quiet; !ctl_q[0] && !REG_WR; endsequence
    sequence s_swu; swu; endsequence
    property p_ev_flag; UPDATE_EVENT |-> UPDATE_FLAG; endproperty
    property p_sticky; UPDATE_FLAG && !clr |=> UPDATE_FLAG; endproperty
    property p_rise; $rose(UPDATE_FLAG) |-> UPDATE_EVENT; endproperty
    property p_idle; !REG_RD |=> REG_RDATA == 32'h0; endproperty
    property p_unmap; REG_RD && REG_ADDR == 8'h20 |=> REG_RDATA == 32'h0; endproperty
    property p_cnt; REG_RD && REG_ADDR == `ATB_CNT_ADDR |=> REG_RDATA == {16'h0, COUNT_VALUE};
    endproperty
    property p_hold; s_quiet [*2] |=> $stable(COUNT_VALUE); endproperty
    property p_udis; ctl_q[1] [*3] |-> !UPDATE_EVENT; endproperty
    property p_swu; s_swu |-> ##[1:3] UPDATE_EVENT; endproperty
    a_ev_flag: assert property (p_ev_flag) else $error("event without flag");
    a_sticky: assert property (p_sticky) else $error("flag dropped");
    a_rise: assert property (p_rise) else $error("flag rose alone");
    a_idle: assert property (p_idle) else $error("read data not idle");
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    a_cnt: assert property (p_cnt) else $error("counter read");
    a_hold: assert property (p_hold) else $error("counter moved while off");
    a_udis: assert property (p_udis) else $error("update while disabled");
    a_swu: assert property (p_swu) else $error("software update lost");
endmodule // atb_chk
bind atb_top atb_chk atb_chk_inst (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .COUNT_VALUE(COUNT_VALUE), .UPDATE_EVENT(UPDATE_EVENT), .UPDATE_FLAG(UPDATE_FLAG));

// File: tb/atb_src_model.sv
// Purpose: Trigger and pin sources facing the timer
// Assumes: One line is selected, the rest carry noise
// Notes:   Selected line only moves on request
`timescale 1ns/1ps
module atb_src_model (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // Requests
    input  wire        go,
    input  wire [2:0]  which,
    input  wire [6:0]  noise,
    // Lines: triggers 3..0, pin0, pin1, external trigger
    output logic [6:0] lines
);
    wire [6:0] m = 7'h01 << which;
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) lines <= 7'h00;
        else lines <= (noise & ~m) | ((lines ^ (go ? m : 7'h00)) & m);
endmodule // atb_src_model

// File: tb/tb_advanced_timer_time_base.sv
// Purpose: Self-checking bench for the time base
// Assumes: Offsets of atb_map.vh
// Notes:   Read results are queued and compared a cycle later
`timescale 1ns/1ps
`include "atb_map.vh"
module tb_advanced_timer_time_base;
    logic        clk = 0, rst_n = 0, wr = 0, rd = 0, go = 0, rd_q = 0;
    logic [7:0]  addr = 0;
    logic [31:0] wdata = 0, seed = 94984, rdata;
    logic [15:0] cnt;
    logic        uev, uflag;
    logic [6:0]  lines, noise = 0;
    logic [2:0]  which = 0;
    logic [31:0] expq[$];
    int          fails = 0, num_checks = 0;
    int          sw[10] = '{0, 4, 5, 6, 1, 'h37, 'h47, 'h67, 'h77, 'h4000};
    int          ws[10] = '{0, 0, 0, 0, 0, 3, 4, 5, 6, 6};
    int          tp[10] = '{0, 0, 0, 0, 2, 2, 1, 1, 2, 2};
    always #5 clk = ~clk;
    atb_top atb_top_inst (.SYS_CLK(clk), .RESETN(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .INTERNAL_TRIG_IN(lines[3:0]),
        .CHAN0_PIN(lines[4]), .CHAN1_PIN(lines[5]), .EXT_TRIGGER_IN(lines[6]),
        .COUNT_VALUE(cnt), .UPDATE_EVENT(uev), .UPDATE_FLAG(uflag));
    atb_src_model atb_src_model_inst (.clk(clk), .rst_n(rst_n), .go(go), .which(which),
        .noise(noise), .lines(lines));
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] s;
        s = v ^ (v << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    always @(posedge clk) begin
        seed <= xs(seed);
        noise <= seed[6:0];
        rd_q <= rd;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    always @(negedge clk) if (rd_q) chk("rdata", expq.pop_front(), rdata);
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr_r(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_r(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask
    // Shadows only load on an update, so every setup issues a software update before its final control write
    task automatic setup(input logic [31:0] ctl, prescale_value, reload_value, rep);
        wr_r(`ATB_CTL0_ADDR, 32'h0);
        wr_r(`ATB_PSC_ADDR, prescale_value);
        wr_r(`ATB_CAR_ADDR, reload_value);
        wr_r(`ATB_REP_ADDR, rep);
        wr_r(`ATB_SWEV_ADDR, 32'h1);
        wr_r(`ATB_CTL0_ADDR, ctl);
    endtask
    task automatic wait_ev(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (uev !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            fails++;
            results();
        end
    endtask
    task automatic period(input int e);
        int n;
        wait_ev(n);
        wait_ev(n);
        chk("period", e, n);
    endtask
    initial begin
        int r;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a <= 32; a += 4) rd_r(a[7:0], 32'h0);
        wr_r(`ATB_REP_ADDR, 32'h1FF);
        wr_r(8'h20, 32'hFFFF);
        rd_r(`ATB_REP_ADDR, 32'hFF);
        r = 2 + seed[2:0];
        setup(32'h01, 32'h1, r, 32'h2);
        period((r + 1) * 6);
        setup(32'h11, 32'h0, 32'h4, 32'h1);
        period(10);
        setup(32'h21, 32'h0, 32'h5, 32'h0);
        period(5);
        setup(32'h21, 32'h2, 32'h4, 32'h1);
        period(24);
        // Leave center mode first, the direction bit is read-only there
        wr_r(`ATB_CTL0_ADDR, 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr_r(`ATB_CTL0_ADDR, {26'h0, i[1:0], 4'h0});
            wr_r(`ATB_CNT_ADDR, 32'h2);
            wr_r(`ATB_SWEV_ADDR, 32'h1);
            rd_r(`ATB_CNT_ADDR, i == 1 ? 32'h4 : 32'h0);
        end
        rd_r(`ATB_FLAG_ADDR, 32'h1);
        wr_r(`ATB_FLAG_ADDR, 32'h1);
        rd_r(`ATB_FLAG_ADDR, 32'h1);
        wr_r(`ATB_FLAG_ADDR, 32'h0);
        rd_r(`ATB_FLAG_ADDR, 32'h0);
        wr_r(`ATB_CTL0_ADDR, 32'h3);
        wr_r(`ATB_SWEV_ADDR, 32'h1);
        repeat (40) @(posedge clk);
        rd_r(`ATB_FLAG_ADDR, 32'h0);
        for (int i = 0; i < 10; i++) begin
            setup(32'h0, 32'h0, 32'hFFFF, 32'h0);
            wr_r(`ATB_SLAVE_ADDR, sw[i]);
            which <= ws[i][2:0];
            wr_r(`ATB_CTL0_ADDR, 32'h1);
            if (tp[i] == 0) repeat (8) @(posedge clk);
            repeat (3 * tp[i]) begin
                @(posedge clk);
                go <= 1'b1;
                @(posedge clk);
                go <= 1'b0;
                repeat (4) @(posedge clk);
            end
            wr_r(`ATB_CTL0_ADDR, 32'h0);
            rd_r(`ATB_CNT_ADDR, tp[i] == 0 ? 32'hA : 32'h3);
        end
        repeat (3) @(posedge clk);
        results();
    end
endmodule // tb_advanced_timer_time_base
